/* verilog/crh_pkg.sv */
/*
  crh_pkg: constants and carrier types for the command/response handshake
  block. Assumes byte-wide host register access over a small local port.
*/
package crh_pkg;
  // byte offsets inside the host register window
  localparam logic [2:0] OFF_HOST_CTRL  = 3'h0;
  localparam logic [2:0] OFF_INIT_CTRL  = 3'h1;
  localparam logic [2:0] OFF_HANDSHAKE  = 3'h2;
  localparam logic [2:0] OFF_STATION    = 3'h3;
  localparam logic [2:0] OFF_PORT_LO_L  = 3'h4;
  localparam logic [2:0] OFF_PORT_LO_H  = 3'h5;
  localparam logic [2:0] OFF_PORT_HI_L  = 3'h6;
  localparam logic [2:0] OFF_PORT_HI_H  = 3'h7;
  // host control byte fields
  localparam int BIT_IRQ_EN_IN  = 0;
  localparam int BIT_IRQ_EN_OUT = 4;
  localparam int BIT_IN_REQUEST = 7;
  // init control byte fields
  localparam int BIT_RUN        = 7;
  localparam int BIT_MCLEAR     = 6;
  // handshake byte fields
  localparam int BIT_CODE_LSB   = 0;
  localparam int BIT_CODE_MSB   = 2;
  localparam int BIT_EXT_ADDR   = 3;
  localparam int BIT_IN_READY   = 4;
  localparam int BIT_OUT_READY  = 7;
  // start-up diagnostic signature, octal 33 and octal 305
  localparam logic [7:0] DIAG_LOW_BYTE  = 8'h1b;
  localparam logic [7:0] DIAG_HIGH_BYTE = 8'hc5;
  // cycles the init sequence takes after master clear drops
  localparam int         INIT_CYCLES = 16;
  localparam logic [4:0] INIT_COUNT  = 5'(INIT_CYCLES);

  // host register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } crh_hreq_s;

  // response posted by the device engine
  typedef struct packed {
    logic [2:0]  code;
    logic [7:0]  station;
    logic [15:0] wordLo;
    logic [15:0] wordHi;
  } crh_resp_s;

  // command handed to the device engine
  typedef struct packed {
    logic [2:0]  code;
    logic        extAddr;
    logic [15:0] wordLo;
    logic [15:0] wordHi;
  } crh_cmd_s;
endpackage

/* verilog/crh_sync_edge.sv */
/*
  crh_sync_edge: two-flop synchroniser with rising-edge pulse.
  Assumes the input is an asynchronous level relative to sys_clk.
*/
`timescale 1ns/1ns
module crh_sync_edge
  import crh_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic asyncIn,
  output logic      levelOut,
  output logic      risePulse
);
  logic meta_r;
  logic lvl_r;
  logic prev_r;

  // first flop feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      lvl_r  <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= asyncIn;
      lvl_r  <= meta_r;
      prev_r <= lvl_r;
    end
  end

  assign levelOut  = lvl_r;
  assign risePulse = lvl_r & ~prev_r;
endmodule

/* verilog/crh_handshake.sv */
/*
  crh_handshake: host-visible command/response handshake registers of a
  line controller. Holds the host control, init, handshake, station and
  data port bytes, grants the port, posts responses, raises vectors.
  Assumes same-clock host access strobes and a device engine on sys_clk;
  respPost is asynchronous from the engine side and is synchronised.
*/
`timescale 1ns/1ns
module crh_handshake
  import crh_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire crh_hreq_s   hostReq,
  output logic [7:0]       hostRdata,
  output crh_cmd_s         cmdOut,
  output logic             cmdValid,
  input  wire logic        cmdIgnore,
  input  wire crh_resp_s   respIn,
  input  wire logic        respPost,
  output logic             respBusy,
  output logic             irqInVector,
  output logic             irqOutVector,
  output logic             runOut,
  output logic             extAddrMode
);
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_GRANTED, ST_RESP} crh_state_e;

  crh_state_e  state_r;
  logic [7:0]  hostCtrl_r;
  logic        mclear_r;
  logic        run_r;
  logic [4:0]  initCnt_r;
  logic [2:0]  code_r;
  logic        extAddr_r;
  logic        inReady_r;
  logic        outReady_r;
  logic [7:0]  station_r;
  logic [15:0] wordLo_r;
  logic [15:0] wordHi_r;
  logic [7:0]  rdata_r;
  logic        cmdValid_r;
  logic        irqIn_r;
  logic        irqOut_r;
  logic        pendResp_r;
  crh_resp_s   pendData_r;
  logic        postLvl;
  logic        postRise;

  logic hostWr;
  logic wrCtrl;
  logic wrInit;
  logic wrHs;
  assign hostWr = hostReq.wr;
  assign wrCtrl = hostWr && hostReq.addr == OFF_HOST_CTRL;
  assign wrInit = hostWr && hostReq.addr == OFF_INIT_CTRL;
  assign wrHs   = hostWr && hostReq.addr == OFF_HANDSHAKE;

  // response strobe arrives from another domain
  crh_sync_edge uPostSync (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .asyncIn   (respPost),
    .levelOut  (postLvl),
    .risePulse (postRise)
  );

  // host control byte
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hostCtrl_r <= 8'h00;
    end else if (mclear_r) begin
      hostCtrl_r <= 8'h00;
    end else if (wrCtrl) begin
      hostCtrl_r <= hostReq.wdata;
    end
  end

  // master clear and run bit
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mclear_r  <= 1'b0;
      run_r     <= 1'b0;
      initCnt_r <= 5'h00;
    end else if (wrInit && hostReq.wdata[BIT_MCLEAR]) begin
      mclear_r  <= 1'b1;
      run_r     <= 1'b0;
      initCnt_r <= INIT_COUNT;
    end else if (mclear_r) begin
      mclear_r <= 1'b0;
    end else if (!run_r && initCnt_r != 5'h00) begin
      initCnt_r <= initCnt_r - 5'h01;
      run_r     <= initCnt_r == 5'h01;
    end
  end

  // pending response latch, held until the port is free
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pendResp_r <= 1'b0;
      pendData_r <= '0;
    end else if (mclear_r) begin
      pendResp_r <= 1'b0; // stale post must not cover the signature
    end else if (postRise && run_r) begin
      pendResp_r <= 1'b1;
      pendData_r <= respIn;
    end else if (state_r == ST_IDLE && !inReady_r && pendResp_r && !outReady_r) begin
      pendResp_r <= 1'b0;
    end
  end

  // port ownership state machine
  always_ff @(posedge sys_clk) begin
    if (!resetn || mclear_r) begin
      state_r    <= ST_INIT;
      inReady_r  <= 1'b0;
      outReady_r <= 1'b0;
      code_r     <= 3'h0;
      extAddr_r  <= 1'b0;
      station_r  <= 8'h00;
      wordLo_r   <= 16'h0000;
      wordHi_r   <= 16'h0000;
      cmdValid_r <= 1'b0;
      irqIn_r    <= 1'b0;
      irqOut_r   <= 1'b0;
    end else begin
      cmdValid_r <= 1'b0;
      irqIn_r    <= 1'b0;
      irqOut_r   <= 1'b0;
      if (wrHs) begin
        extAddr_r <= hostReq.wdata[BIT_EXT_ADDR];
      end
      // host loads data port words
      if (hostWr && state_r != ST_INIT) begin
        case (hostReq.addr)
          OFF_PORT_LO_L: wordLo_r[7:0]  <= hostReq.wdata;
          OFF_PORT_LO_H: wordLo_r[15:8] <= hostReq.wdata;
          OFF_PORT_HI_L: wordHi_r[7:0]  <= hostReq.wdata;
          OFF_PORT_HI_H: wordHi_r[15:8] <= hostReq.wdata;
          OFF_STATION:   station_r      <= hostReq.wdata;
          default: ;
        endcase
      end
      case (state_r)
        ST_INIT: begin
          if (run_r) begin
            wordLo_r <= {8'h00, DIAG_LOW_BYTE};
            wordHi_r <= {8'h00, DIAG_HIGH_BYTE};
            state_r  <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (pendResp_r && !outReady_r) begin
            code_r     <= pendData_r.code;
            station_r  <= pendData_r.station;
            wordLo_r   <= pendData_r.wordLo;
            wordHi_r   <= pendData_r.wordHi;
            outReady_r <= 1'b1;
            irqOut_r   <= hostCtrl_r[BIT_IRQ_EN_OUT];
            state_r    <= ST_RESP;
          end else if (hostCtrl_r[BIT_IN_REQUEST] && !outReady_r) begin
            inReady_r <= 1'b1;
            irqIn_r   <= hostCtrl_r[BIT_IRQ_EN_IN];
            state_r   <= ST_GRANTED;
          end
        end
        ST_GRANTED: begin
          if (wrHs && hostReq.wdata[BIT_CODE_MSB:BIT_CODE_LSB] != 3'h0) begin
            code_r     <= hostReq.wdata[BIT_CODE_MSB:BIT_CODE_LSB];
            inReady_r  <= 1'b0;
            cmdValid_r <= 1'b1;
            state_r    <= ST_IDLE;
          end
        end
        ST_RESP: begin
          if (wrHs && !hostReq.wdata[BIT_OUT_READY]) begin
            outReady_r <= 1'b0;
            // held request regranted in idle once no response is pending
            state_r    <= ST_IDLE;
          end
        end
        default: state_r <= ST_INIT;
      endcase
    end
  end

  // read mux, registered
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (hostReq.rd) begin
      case (hostReq.addr)
        OFF_HOST_CTRL: rdata_r <= hostCtrl_r;
        OFF_INIT_CTRL: rdata_r <= {run_r, mclear_r, 6'h00};
        OFF_HANDSHAKE: rdata_r <= {outReady_r, 2'b00, inReady_r, extAddr_r, code_r};
        OFF_STATION:   rdata_r <= station_r;
        OFF_PORT_LO_L: rdata_r <= wordLo_r[7:0];
        OFF_PORT_LO_H: rdata_r <= wordLo_r[15:8];
        OFF_PORT_HI_L: rdata_r <= wordHi_r[7:0];
        OFF_PORT_HI_H: rdata_r <= wordHi_r[15:8];
        default:       rdata_r <= 8'h00;
      endcase
    end
  end

  // command handed to engine; engine flags no-request key via cmdIgnore
  crh_cmd_s cmd_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd_r <= '0;
    end else if (cmdValid_r && !cmdIgnore) begin
      cmd_r <= '{code: code_r, extAddr: extAddr_r, wordLo: wordLo_r, wordHi: wordHi_r};
    end
  end

  // busy echo toward engine; level is synchronised already
  logic respBusy_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      respBusy_r <= 1'b0;
    end else begin
      respBusy_r <= pendResp_r | outReady_r | postLvl;
    end
  end

  logic cmdValidOut_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmdValidOut_r <= 1'b0;
    end else begin
      cmdValidOut_r <= cmdValid_r && !cmdIgnore;
    end
  end

  assign hostRdata    = rdata_r;
  assign cmdOut       = cmd_r;
  assign cmdValid     = cmdValidOut_r;
  assign respBusy     = respBusy_r;
  assign irqInVector  = irqIn_r;
  assign irqOutVector = irqOut_r;
  assign runOut       = run_r;
  assign extAddrMode  = extAddr_r;
endmodule

/* sim/crh_handshake_assertions.sv */
/* crh_handshake_assertions: port checker for crh_handshake.
   Assumes it is bound onto every crh_handshake instance. */
`timescale 1ns/1ns
module crh_handshake_assertions
  import crh_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire crh_hreq_s  hostReq,
  input wire logic [7:0] hostRdata,
  input wire logic       cmdValid,
  input wire logic       respBusy,
  input wire logic       irqInVector,
  input wire logic       irqOutVector,
  input wire logic       runOut,
  input wire logic       extAddrMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic hsWr;
  logic mcWr;
  // decoded host writes
  assign hsWr = hostReq.wr && hostReq.addr == OFF_HANDSHAKE;
  assign mcWr = hostReq.wr && hostReq.addr == OFF_INIT_CTRL && hostReq.wdata[BIT_MCLEAR];
  property p_inPulse; irqInVector |=> !irqInVector; endproperty
  a_inPulse: assert property (p_inPulse) else $error("input irq too long");
  property p_outPulse; irqOutVector |=> !irqOutVector; endproperty
  a_outPulse: assert property (p_outPulse) else $error("output irq too long");
  property p_inRun; irqInVector |-> runOut; endproperty
  a_inRun: assert property (p_inRun) else $error("grant before run");
  property p_outBusy; irqOutVector |-> respBusy; endproperty
  a_outBusy: assert property (p_outBusy) else $error("output irq w/o response");
  property p_cmdSrc; cmdValid |-> $past(hsWr && hostReq.wdata[2:0] != 3'h0, 2); endproperty
  a_cmdSrc: assert property (p_cmdSrc) else $error("command w/o code write");
  property p_cmdRun; cmdValid |-> runOut ##1 !cmdValid; endproperty
  a_cmdRun: assert property (p_cmdRun) else $error("command before run");
  property p_ext; hsWr |=> extAddrMode == $past(hostReq.wdata[BIT_EXT_ADDR]); endproperty
  a_ext: assert property (p_ext) else $error("ext mode not taken");
  property p_mclr; mcWr |-> ##2 (!runOut && !extAddrMode); endproperty
  a_mclr: assert property (p_mclr) else $error("master clear left state");
  property p_runUp; mcWr |-> ##[3:40] runOut; endproperty
  a_runUp: assert property (p_runUp) else $error("run bit never set");
  property p_postRun; $rose(respBusy) |-> runOut; endproperty
  a_postRun: assert property (p_postRun) else $error("response before run");
  property p_rdHold; !$past(hostReq.rd) |-> $stable(hostRdata); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  c_cmd: cover property (cmdValid);
  c_in: cover property (irqInVector);
  c_out: cover property (irqOutVector);
endmodule
bind crh_handshake crh_handshake_assertions chk (.sys_clk(sys_clk), .resetn(resetn),
  .hostReq(hostReq), .hostRdata(hostRdata), .cmdValid(cmdValid), .respBusy(respBusy),
  .irqInVector(irqInVector), .irqOutVector(irqOutVector), .runOut(runOut),
  .extAddrMode(extAddrMode));

/* sim/crh_host_model.sv */
/* crh_host_model: host program side of the register window.
   Assumes byte strobes taken at the rising edge of sys_clk. */
`timescale 1ns/1ns
module crh_host_model
  import crh_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] hostRdata,
  output crh_hreq_s       hostReq
);
  initial hostReq = '0;
  // one write; released lines show the inverse, not stale data
  task automatic wrB(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk); #2;
    hostReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk); #2;
    hostReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // one read, data taken a cycle after the strobe
  task automatic rdB(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk); #2;
    hostReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk); #2;
    hostReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    @(posedge sys_clk); #2;
    d = hostRdata;
  endtask
  task automatic reqPort(input logic [7:0] ctl);
    wrB(OFF_HOST_CTRL, ctl);
  endtask
  task automatic loadCmd(input crh_cmd_s c);
    wrB(OFF_PORT_LO_L, c.wordLo[7:0]);
    wrB(OFF_PORT_LO_H, c.wordLo[15:8]);
    wrB(OFF_PORT_HI_L, c.wordHi[7:0]);
    wrB(OFF_PORT_HI_H, c.wordHi[15:8]);
    wrB(OFF_HANDSHAKE, {4'h0, c.extAddr, c.code});
  endtask
endmodule

/* sim/csr_command_response_handshake_test.sv */
/* csr_command_response_handshake_test: self-checking bench.
   Assumes the host model drives the register window. */
`timescale 1ns/1ns
module csr_command_response_handshake_test import crh_pkg::*;;
  logic sys_clk, resetn, cmdValid, cmdIgnore, respPost, respBusy;
  logic irqInVector, irqOutVector, runOut, extAddrMode;
  logic [7:0] hostRdata, b;
  crh_hreq_s  hostReq;
  crh_cmd_s   cmdOut, c, e, q[$];
  crh_resp_s  respIn;
  int n_fail = 0, checks = 0, seed = 65, inIrqs = 0, outIrqs = 0;
  crh_handshake uut (.sys_clk(sys_clk), .resetn(resetn), .hostReq(hostReq),
    .hostRdata(hostRdata), .cmdOut(cmdOut), .cmdValid(cmdValid), .cmdIgnore(cmdIgnore),
    .respIn(respIn), .respPost(respPost), .respBusy(respBusy), .irqInVector(irqInVector),
    .irqOutVector(irqOutVector), .runOut(runOut), .extAddrMode(extAddrMode));
  crh_host_model host (.sys_clk(sys_clk), .hostRdata(hostRdata), .hostReq(hostReq));
  always #20 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (e !== g) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for an interrupt count
  task automatic waitIrq(input bit o, input int want);
    for (int t = 0; t < 80 && (o ? outIrqs : inIrqs) < want; t++) @(posedge sys_clk);
  endtask
  // interrupt counting and command model compare
  always @(posedge sys_clk) begin
    if (irqInVector === 1'b1) inIrqs++;
    if (irqOutVector === 1'b1) outIrqs++;
    if (cmdValid === 1'b1) begin
      chk("cmdQueued", 1, 16'(q.size() > 0));
      if (q.size() > 0) begin
        e = q.pop_front();
        chk("cmdLo", e.wordLo, cmdOut.wordLo);
        chk("cmdHi", e.wordHi, cmdOut.wordHi);
        chk("cmdCode", {e.extAddr, e.code}, {cmdOut.extAddr, cmdOut.code});
      end
    end
  end
  initial begin
    #800000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    sys_clk = 0; resetn = 0; cmdIgnore = 0; respPost = 0; respIn = '0;
    repeat (5) @(posedge sys_clk);
    #2 resetn = 1;
    host.rdB(OFF_HOST_CTRL, b);
    chk("ctrlReset", 0, b);
    host.wrB(OFF_INIT_CTRL, 8'h40);
    for (int t = 0; t < 40 && runOut !== 1'b1; t++) @(posedge sys_clk);
    host.rdB(OFF_INIT_CTRL, b);
    chk("runBit", 1, b[BIT_RUN]);
    host.rdB(OFF_PORT_LO_L, b);
    chk("diagLo", 8'h1b, b);
    host.rdB(OFF_PORT_HI_L, b);
    chk("diagHi", 8'hc5, b);
    host.reqPort(8'h91);
    // every command code, request held for the series
    for (int k = 1; k <= 7; k++) begin
      waitIrq(0, k);
      chk("grantIrq", k, inIrqs);
      host.rdB(OFF_HANDSHAKE, b);
      chk("inReady", 1, b[BIT_IN_READY]);
      c = '{code: 3'(k), extAddr: 1'($random(seed)), wordLo: 16'($random(seed)),
            wordHi: 16'($random(seed))};
      q.push_back(c);
      respIn = crh_resp_s'(43'({$random(seed), $random(seed)}));
      @(posedge sys_clk); #2 respPost = 1;
      host.loadCmd(c);
      chk("respHeld", k - 1, outIrqs);
      chk("extMode", c.extAddr, extAddrMode);
      waitIrq(1, k);
      chk("outIrq", k, outIrqs);
      chk("busyShown", 1, respBusy);
      #2 respPost = 0;
      host.rdB(OFF_HANDSHAKE, b);
      chk("outReady", {1'b1, respIn.code}, {b[BIT_OUT_READY], b[2:0]});
      host.rdB(OFF_STATION, b);
      chk("station", respIn.station, b);
      host.rdB(OFF_PORT_LO_L, b);
      chk("respWord", respIn.wordLo[7:0], b);
      host.wrB(OFF_HANDSHAKE, 8'h00);
    end
    // port handed back, then returned by a no-request command
    waitIrq(0, 8);
    chk("regrant", 8, inIrqs);
    host.wrB(OFF_HOST_CTRL, 8'h11);
    cmdIgnore = 1;
    host.loadCmd(c);
    repeat (3) @(posedge sys_clk);
    #2 cmdIgnore = 0;
    repeat (30) @(posedge sys_clk);
    chk("noGrant", 8, inIrqs);
    chk("busyIdle", 0, respBusy);
    chk("queueEmpty", 0, 16'(q.size()));
    tally_and_finish();
  end
endmodule
